//--- hw/run_arming_segment_select.sv
// Run control, arming, segment and sequence selection for two channels.
// Summary of operation
// - Arbitrary output switches segment only on strobe.
// - Sequence mode takes code as sequence number.
// - Each channel has own code and strobe.
// - Event input has programmable threshold and slope.
// - Event acts on both channels same cycle.
// - Event can advance the sequence step.
// - Exactly one of continuous, triggered, gated.
// - Only remote command sets armed state.
// - Armed: trigger, event or remote enable starts.
// - Once enabled, only output off, remote abort or the end of a once-through sequence stops.
// - Self-armed output runs immediately when on.
// - Armed output waits for valid enable.
// - Idle waveform selection while not enabled.
// - Remote enable source ignores event input.
// - Exactly one enable source active.
// - Abort source is remote command only.
// - Segment loop counter, one to one million.
// - Sequence loop counter, one to one million.
// - Jump flag: auto advance or await event.
// - Jump signal selects the stepping event source.
// - Advance mode ignored outside sequence functions.
// - Trigger reacts to chosen edges, except in gated mode, which follows its level.
`timescale 1ns/1ps
module run_arming_segment_select
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // AXI4-Lite write address and data
  input wire logic awvalid,
  output logic awready,
  input wire logic [run_ctrl_pkg::ADDR_W-1:0] awaddr,
  input wire logic [2:0] awprot,
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  // AXI4-Lite write response
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  // AXI4-Lite read
  input wire logic arvalid,
  output logic arready,
  input wire logic [run_ctrl_pkg::ADDR_W-1:0] araddr,
  input wire logic [2:0] arprot,
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  // Control pins
  input wire logic [run_ctrl_pkg::CODE_W-1:0] selCode [run_ctrl_pkg::NUM_CH],
  input wire logic [run_ctrl_pkg::NUM_CH-1:0] selValid,
  input wire logic eventIn,
  input wire logic trigIn,
  // Waveform engine handshake
  input wire logic [run_ctrl_pkg::NUM_CH-1:0] segDone,
  // Outputs to the engine and comparators
  output run_ctrl_pkg::chOut_t chOut [run_ctrl_pkg::NUM_CH],
  output logic [run_ctrl_pkg::LEVEL_W-1:0] evtThreshold,
  output logic [run_ctrl_pkg::LEVEL_W-1:0] trigThreshold
);
  import run_ctrl_pkg::*;

  cfg_t cfg;
  logic [31:0] levels;
  chCtrl_t chCtrl [NUM_CH];
  logic [LOOP_W-1:0] segLoops [NUM_CH];
  logic [LOOP_W-1:0] seqLoops [NUM_CH];
  runState_t state [NUM_CH];
  logic [CODE_W-1:0] activeCode [NUM_CH];
  logic [STEP_W-1:0] stepIdx [NUM_CH];
  logic [7:0] cmd;
  logic awHave;
  logic wHave;
  logic [ADDR_W-1:0] awAddrQ;
  logic [31:0] wDataQ;
  logic [3:0] wStrbQ;
  logic doWrite;
  logic evtLevel;
  logic evtPulse;
  logic trigLevel;
  logic trigPulse;

  function automatic logic [31:0] mergeStrb(input logic [31:0] old, input logic [31:0] nw,
                                             input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int b = 0; b < 4; b++)
      if (strb[b])
        res[8*b +: 8] = nw[8*b +: 8];
    return res;
  endfunction : mergeStrb

  function automatic logic [LOOP_W-1:0] clampLoop(input logic [31:0] v);
    logic [LOOP_W-1:0] res;
    res = v[LOOP_W-1:0];
    if (v > {12'h000, LOOP_MAX})
      res = LOOP_MAX;
    else if (v[LOOP_W-1:0] < LOOP_MIN)
      res = LOOP_MIN;
    return res;
  endfunction : clampLoop

  function automatic logic isMapped(input logic [ADDR_W-1:0] a);
    logic hit;
    hit = (a == GLOBAL_CFG_ADDR) || (a == LEVEL_ADDR) || (a == COMMAND_ADDR);
    if ((a[7:4] >= CH0_BLOCK) && (a[7:4] < CH0_BLOCK + 4'(NUM_CH)))
      hit = 1'b1;
    return hit;
  endfunction : isMapped

  // Write channel: address and data are taken in either order.
  assign doWrite = awHave && wHave && !bvalid;

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      awready <= 1'b0;
      awHave <= 1'b0;
      awAddrQ <= '0;
    end
    else if (awvalid && awready)
    begin
      awready <= 1'b0;
      awHave <= 1'b1;
      awAddrQ <= awaddr;
    end
    else
    begin
      if (doWrite)
        awHave <= 1'b0;
      awready <= !awHave && !bvalid;
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      wready <= 1'b0;
      wHave <= 1'b0;
      wDataQ <= '0;
      wStrbQ <= '0;
    end
    else if (wvalid && wready)
    begin
      wready <= 1'b0;
      wHave <= 1'b1;
      wDataQ <= wdata;
      wStrbQ <= wstrb;
    end
    else
    begin
      if (doWrite)
        wHave <= 1'b0;
      wready <= !wHave && !bvalid;
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      bvalid <= 1'b0;
      bresp <= RESP_OKAY;
    end
    else if (doWrite)
    begin
      bvalid <= 1'b1;
      bresp <= isMapped(awAddrQ) ? RESP_OKAY : RESP_SLVERR;
    end
    else if (bready)
      bvalid <= 1'b0;
  end

  // Shared configuration and remote commands.
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      cfg <= cfg_t'(CFG_RST);
      levels <= LEVEL_RST;
      cmd <= '0;
    end
    else
    begin
      cmd <= '0;
      if (doWrite && awAddrQ == GLOBAL_CFG_ADDR)
        cfg <= cfg_t'(mergeStrb(cfg, wDataQ, wStrbQ) & CFG_MASK);
      if (doWrite && awAddrQ == LEVEL_ADDR)
        levels <= mergeStrb(levels, wDataQ, wStrbQ) & LEVEL_MASK;
      if (doWrite && awAddrQ == COMMAND_ADDR && wStrbQ[0])
        cmd <= wDataQ[7:0];
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      evtThreshold <= '0;
      trigThreshold <= '0;
    end
    else
    begin
      evtThreshold <= levels[LEVEL_W-1:0];
      trigThreshold <= levels[TRIG_LEVEL_LSB +: LEVEL_W];
    end
  end

  // Read channel answers one cycle after the address is taken.
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      arready <= 1'b0;
      rvalid <= 1'b0;
      rdata <= '0;
      rresp <= RESP_OKAY;
    end
    else if (arvalid && arready)
    begin
      arready <= 1'b0;
      rvalid <= 1'b1;
      rresp <= isMapped(araddr) ? RESP_OKAY : RESP_SLVERR;
      rdata <= '0;
      if (araddr == GLOBAL_CFG_ADDR)
        rdata <= cfg;
      else if (araddr == LEVEL_ADDR)
        rdata <= levels;
      for (int c = 0; c < NUM_CH; c++)
        if (araddr[7:4] == CH0_BLOCK + 4'(c))
          case (araddr[3:2])
            CH_CTRL_IDX: rdata <= chCtrl[c];
            CH_SEGLOOP_IDX: rdata <= {12'h000, segLoops[c]};
            CH_SEQLOOP_IDX: rdata <= {12'h000, seqLoops[c]};
            CH_STATUS_IDX: rdata <= {8'h00, stepIdx[c], activeCode[c], 4'h0, state[c]};
            default: rdata <= '0;
          endcase
    end
    else if (rvalid)
    begin
      if (rready)
        rvalid <= 1'b0;
    end
    else
      arready <= 1'b1;
  end

  // One event detector serves both channels, so both see the same pulse.
  edge_sync eventSync
  (
    .clk(clk),
    .rst(rst),
    .pin(eventIn),
    .slope(cfg.evtSlope),
    .level(evtLevel),
    .edgePulse(evtPulse)
  );

  edge_sync trigSync
  (
    .clk(clk),
    .rst(rst),
    .pin(trigIn),
    .slope(cfg.trigSlope),
    .level(trigLevel),
    .edgePulse(trigPulse)
  );

  for (genvar c = 0; c < NUM_CH; c++)
  begin : chan
    logic validPulse;
    logic [CODE_W-1:0] codeQ1;
    logic [CODE_W-1:0] codeQ2;
    logic [CODE_W-1:0] codeQ3;
    logic armed;
    logic isSeq;
    logic chEvt;
    logic jumpEvt;
    logic enableHit;
    logic burst;
    logic runGate;
    logic waitJump;
    logic advance;
    logic finish;
    logic [LOOP_W-1:0] segCnt;
    logic [LOOP_W-1:0] seqCnt;
    logic chWrite;

    assign chWrite = doWrite && awAddrQ[7:4] == CH0_BLOCK + 4'(c);

    always_ff @(posedge clk)
    begin
      if (rst)
      begin
        chCtrl[c] <= chCtrl_t'(CH_CTRL_RST);
        segLoops[c] <= LOOP_MIN;
        seqLoops[c] <= LOOP_MIN;
      end
      else if (chWrite)
        case (awAddrQ[3:2])
          CH_CTRL_IDX: chCtrl[c] <= chCtrl_t'(mergeStrb(chCtrl[c], wDataQ, wStrbQ) & CH_CTRL_MASK);
          CH_SEGLOOP_IDX: segLoops[c] <= clampLoop(mergeStrb({12'h000, segLoops[c]}, wDataQ, wStrbQ));
          CH_SEQLOOP_IDX: seqLoops[c] <= clampLoop(mergeStrb({12'h000, seqLoops[c]}, wDataQ, wStrbQ));
          default: ;
        endcase
    end

    edge_sync validSync
    (
      .clk(clk),
      .rst(rst),
      .pin(selValid[c]),
      .slope(SLOPE_RISE),
      .level(),
      .edgePulse(validPulse)
    );

    // The code takes the same three-stage path as its strobe, so the pair stays aligned.
    always_ff @(posedge clk)
    begin
      if (rst)
      begin
        codeQ1 <= '0;
        codeQ2 <= '0;
        codeQ3 <= '0;
      end
      else
      begin
        codeQ1 <= selCode[c];
        codeQ2 <= codeQ1;
        codeQ3 <= codeQ2;
      end
    end

    always_ff @(posedge clk)
    begin
      if (rst)
        activeCode[c] <= '0;
      else if (validPulse)
        activeCode[c] <= codeQ3;
    end

    always_ff @(posedge clk)
    begin
      if (rst)
        armed <= 1'b0;
      else if (cmd[CMD_ARM_LSB + c])
        armed <= 1'b1;
      else if (cmd[CMD_SELFARM_LSB + c])
        armed <= 1'b0;
    end

    assign isSeq = (chCtrl[c].func == FN_SEQ) || (chCtrl[c].func == FN_ADVSEQ);
    assign chEvt = evtPulse && chCtrl[c].evtRespond;
    assign jumpEvt = chCtrl[c].jumpOnTrig ? trigPulse : chEvt;

    always_comb
    begin
      case (chCtrl[c].enSrc)
        EN_BUS: enableHit = cmd[CMD_ENABLE_LSB + c];
        EN_EVENT: enableHit = chEvt;
        EN_TRIG: enableHit = trigPulse;
        default: enableHit = 1'b0;
      endcase
    end

    always_comb
    begin
      case (cfg.runMode)
        RUN_CONT: runGate = 1'b1;
        RUN_TRIG: runGate = burst;
        RUN_GATED: runGate = trigLevel;
        default: runGate = 1'b0;
      endcase
    end

    // In triggered mode one trigger plays one segment pass.
    always_ff @(posedge clk)
    begin
      if (rst || state[c] != ST_RUN)
        burst <= 1'b0;
      else if (trigPulse)
        burst <= 1'b1;
      else if (segDone[c])
        burst <= 1'b0;
    end

    // Step bookkeeping; stepped mode waits for an event after every segment pass.
    always_comb
    begin
      advance = 1'b0;
      if (state[c] == ST_RUN && isSeq && runGate)
      begin
        if (waitJump)
          advance = jumpEvt;
        else if (segDone[c] && chCtrl[c].adv != ADV_STEPPED)
          advance = (segCnt + 20'h00001 >= segLoops[c]) && !chCtrl[c].jumpFlag;
      end
    end

    assign finish = advance && (stepIdx[c] + 8'h01 >= chCtrl[c].numSteps) &&
                    (chCtrl[c].func == FN_SEQ || seqCnt + 20'h00001 >= seqLoops[c]) &&
                    chCtrl[c].adv == ADV_ONCE;

    always_ff @(posedge clk)
    begin
      if (rst || !isSeq || state[c] != ST_RUN || validPulse)
      begin
        stepIdx[c] <= '0;
        segCnt <= '0;
        seqCnt <= '0;
        waitJump <= 1'b0;
      end
      else if (advance)
      begin
        waitJump <= 1'b0;
        segCnt <= '0;
        if (stepIdx[c] + 8'h01 >= chCtrl[c].numSteps)
        begin
          stepIdx[c] <= '0;
          if (chCtrl[c].func == FN_ADVSEQ && seqCnt + 20'h00001 < seqLoops[c])
            seqCnt <= seqCnt + 20'h00001;
          else
            seqCnt <= '0;
        end
        else
          stepIdx[c] <= stepIdx[c] + 8'h01;
      end
      else if (segDone[c] && runGate && !waitJump)
      begin
        if (chCtrl[c].adv == ADV_STEPPED)
          waitJump <= 1'b1;
        else if (segCnt + 20'h00001 >= segLoops[c])
        begin
          segCnt <= '0;
          waitJump <= chCtrl[c].jumpFlag;
        end
        else
          segCnt <= segCnt + 20'h00001;
      end
    end

    // Output off parks the channel; otherwise an armed remote abort or a finished sequence leaves the run state.
    always_ff @(posedge clk)
    begin
      if (rst)
        state[c] <= ST_OFF;
      else if (!cfg.outputOn[c])
        state[c] <= ST_OFF;
      else
        case (state[c])
          ST_OFF: state[c] <= armed ? ST_WAIT : ST_RUN;
          ST_WAIT:
          begin
            if (!armed || enableHit)
              state[c] <= ST_RUN;
          end
          ST_RUN:
          begin
            if (armed && cmd[CMD_ABORT_LSB + c])
              state[c] <= ST_WAIT;
            else if (finish)
              state[c] <= ST_DONE;
          end
          ST_DONE:
          begin
            if (armed && cmd[CMD_ABORT_LSB + c])
              state[c] <= ST_WAIT;
          end
          default: state[c] <= ST_OFF;
        endcase
    end

    always_ff @(posedge clk)
    begin
      if (rst)
        chOut[c] <= '0;
      else
      begin
        chOut[c].genRun <= (state[c] == ST_RUN) && runGate;
        chOut[c].waiting <= (state[c] == ST_WAIT);
        chOut[c].idleShape <= chCtrl[c].idleSel;
        chOut[c].activeCode <= activeCode[c];
        chOut[c].stepIdx <= stepIdx[c];
        chOut[c].stepPulse <= advance;
      end
    end
  end

endmodule : run_arming_segment_select

//--- hw/run_ctrl_pkg.sv
// Shared constants, register layouts and carrier types of the run controller.
package run_ctrl_pkg;

  localparam int NUM_CH = 2;
  localparam int CODE_W = 8;
  localparam int STEP_W = 8;
  localparam int LOOP_W = 20;
  localparam int LEVEL_W = 12;
  localparam int ADDR_W = 8;

  // Byte addresses of the shared registers.
  localparam logic [ADDR_W-1:0] GLOBAL_CFG_ADDR = 8'h00;
  localparam logic [ADDR_W-1:0] LEVEL_ADDR = 8'h04;
  localparam logic [ADDR_W-1:0] COMMAND_ADDR = 8'h08;

  // Channel blocks: address bits [7:4] select the channel, bits [3:2] the register.
  localparam logic [3:0] CH0_BLOCK = 4'h1;
  localparam logic [1:0] CH_CTRL_IDX = 2'h0;
  localparam logic [1:0] CH_SEGLOOP_IDX = 2'h1;
  localparam logic [1:0] CH_SEQLOOP_IDX = 2'h2;
  localparam logic [1:0] CH_STATUS_IDX = 2'h3;

  // Command register bit groups, one bit per channel in each.
  localparam int CMD_ARM_LSB = 0;
  localparam int CMD_ENABLE_LSB = 2;
  localparam int CMD_ABORT_LSB = 4;
  localparam int CMD_SELFARM_LSB = 6;

  localparam logic [31:0] CFG_MASK = 32'h0000033f;
  localparam logic [31:0] LEVEL_MASK = 32'h0fff0fff;
  localparam logic [31:0] CH_CTRL_MASK = 32'h00ff1ff7;
  localparam logic [31:0] CFG_RST = 32'h00000000;
  localparam logic [31:0] LEVEL_RST = 32'h00000000;
  localparam logic [31:0] CH_CTRL_RST = 32'h00010000;
  localparam int TRIG_LEVEL_LSB = 16;

  localparam logic [LOOP_W-1:0] LOOP_MIN = 20'h00001;
  localparam logic [LOOP_W-1:0] LOOP_MAX = 20'hf4240;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {RUN_CONT = 2'h0, RUN_TRIG = 2'h1, RUN_GATED = 2'h2} runMode_t;
  typedef enum logic [1:0] {SLOPE_RISE = 2'h0, SLOPE_FALL = 2'h1, SLOPE_EITHER = 2'h2} slope_t;
  typedef enum logic [2:0] {
    FN_STD = 3'h0, FN_ARB = 3'h1, FN_SEQ = 3'h2, FN_ADVSEQ = 3'h3, FN_MOD = 3'h4, FN_PULSE = 3'h5
  } func_t;
  typedef enum logic [1:0] {ADV_AUTO = 2'h0, ADV_ONCE = 2'h1, ADV_STEPPED = 2'h2} adv_t;
  typedef enum logic [1:0] {EN_BUS = 2'h0, EN_EVENT = 2'h1, EN_TRIG = 2'h2} enSrc_t;
  typedef enum logic [1:0] {IDLE_DC = 2'h0, IDLE_WAVE = 2'h1, IDLE_SEQ = 2'h2} idle_t;
  typedef enum logic [3:0] {
    ST_OFF = 4'b0001, ST_WAIT = 4'b0010, ST_RUN = 4'b0100, ST_DONE = 4'b1000
  } runState_t;

  typedef struct packed {
    logic [21:0] rsvdHi;
    logic [1:0] outputOn;
    logic [1:0] rsvdLo;
    slope_t evtSlope;
    slope_t trigSlope;
    runMode_t runMode;
  } cfg_t;

  typedef struct packed {
    logic [7:0] rsvdHi;
    logic [STEP_W-1:0] numSteps;
    logic [2:0] rsvdMid;
    logic evtRespond;
    logic jumpOnTrig;
    logic jumpFlag;
    idle_t idleSel;
    enSrc_t enSrc;
    adv_t adv;
    logic rsvdLo;
    func_t func;
  } chCtrl_t;

  typedef struct packed {
    logic genRun;
    logic waiting;
    idle_t idleShape;
    logic [CODE_W-1:0] activeCode;
    logic [STEP_W-1:0] stepIdx;
    logic stepPulse;
  } chOut_t;

endpackage : run_ctrl_pkg

//--- hw/edge_sync.sv
// Three-stage pin synchroniser with slope-selected edge pulse.
`timescale 1ns/1ps
module edge_sync
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Pin and slope choice
  input wire logic pin,
  input wire run_ctrl_pkg::slope_t slope,
  // Filtered level and edge pulse
  output logic level,
  output logic edgePulse
);
  import run_ctrl_pkg::*;

  logic s1;
  logic s2;
  logic s3;
  logic agreed;
  logic rising;
  logic falling;

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      s1 <= 1'b0;
      s2 <= 1'b0;
      s3 <= 1'b0;
    end
    else
    begin
      s1 <= pin;
      s2 <= s1;
      s3 <= s2;
    end
  end

  // A change counts only once the second and third stages agree.
  assign agreed = (s2 == s3) && (s3 != level);
  assign rising = agreed && s3;
  assign falling = agreed && !s3;

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      level <= 1'b0;
      edgePulse <= 1'b0;
    end
    else
    begin
      if (agreed)
        level <= s3;
      case (slope)
        SLOPE_RISE: edgePulse <= rising;
        SLOPE_FALL: edgePulse <= falling;
        SLOPE_EITHER: edgePulse <= rising || falling;
        default: edgePulse <= 1'b0;
      endcase
    end
  end

endmodule : edge_sync

//--- verif/run_arming_segment_select_monitor.sv
// Port-level assertions for the run controller.
`timescale 1ns/1ps
module run_arming_segment_select_monitor
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Register bus
  input wire logic awvalid,
  input wire logic awready,
  input wire logic wvalid,
  input wire logic wready,
  input wire logic bvalid,
  input wire logic bready,
  input wire logic [1:0] bresp,
  input wire logic arvalid,
  input wire logic arready,
  input wire logic rvalid,
  input wire logic rready,
  input wire logic [31:0] rdata,
  input wire logic [1:0] rresp,
  // Pins and channel outputs
  input wire logic [run_ctrl_pkg::NUM_CH-1:0] selValid,
  input wire run_ctrl_pkg::chOut_t chOut [run_ctrl_pkg::NUM_CH]
);
  import run_ctrl_pkg::*;
  default clocking mon_clk @(posedge clk);
  endclocking
  default disable iff (rst);
  a_bresp_stand: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write response dropped early");
  a_rdata_stand: assert property (rvalid && !rready |=> rvalid && $stable(rdata) && $stable(rresp))
    else $error("read answer dropped early");
  a_read_answer: assert property (arvalid && arready |=> rvalid && !arready)
    else $error("read answer late");
  // The write answer comes one cycle after both halves are held, not at the next edge.
  a_write_answer: assert property (awvalid && awready && wvalid && wready |=>
    !awready ##1 (bvalid && !awready))
    else $error("write response late");
  a_slverr_zero: assert property (rvalid && rresp == RESP_SLVERR |-> rdata == 32'h0)
    else $error("refused read returned data");
  // A code may move only some cycles after a strobe rise, never once the strobe has rested eight cycles.
  a_code_held0: assert property ((!selValid[0]) [*8] |=> $stable(chOut[0].activeCode))
    else $error("channel 0 code moved without strobe");
  a_code_held1: assert property ((!selValid[1]) [*8] |=> $stable(chOut[1].activeCode))
    else $error("channel 1 code moved without strobe");
  a_wait_quiet: assert property (chOut[0].waiting || chOut[1].waiting |->
    !(chOut[0].waiting && chOut[0].genRun) && !(chOut[1].waiting && chOut[1].genRun))
    else $error("waiting channel produced output");
  a_step_single: assert property (chOut[0].stepPulse |=> !chOut[0].stepPulse)
    else $error("step pulse longer than one cycle");
endmodule : run_arming_segment_select_monitor

bind run_arming_segment_select run_arming_segment_select_monitor i_mon (.clk, .rst, .awvalid,
  .awready, .wvalid, .wready, .bvalid, .bready, .bresp, .arvalid, .arready, .rvalid, .rready,
  .rdata, .rresp, .selValid, .chOut);

//--- verif/control_source_model.sv
// Behavioural control source: select lines, strobes, event and trigger pins, segment ends.
`timescale 1ns/1ps
module control_source_model
(
  // Clock
  input wire logic clk,
  // Channel state from the block
  input wire run_ctrl_pkg::chOut_t chOut [run_ctrl_pkg::NUM_CH],
  // Pins toward the block
  output logic [run_ctrl_pkg::CODE_W-1:0] selCode [run_ctrl_pkg::NUM_CH],
  output logic [run_ctrl_pkg::NUM_CH-1:0] selValid,
  output logic eventIn,
  output logic trigIn,
  output logic [run_ctrl_pkg::NUM_CH-1:0] segDone
);
  import run_ctrl_pkg::*;
  logic [2:0] pass = 3'h0;
  initial
  begin
    selCode[0] = 8'h00;
    selCode[1] = 8'h00;
    selValid = 2'b00;
    eventIn = 1'b0;
    trigIn = 1'b0;
    segDone = 2'b00;
  end
  // Codes are scrambled once their hold time ends, so a late latch picks up garbage.
  task strobe(input logic [CODE_W-1:0] c0, input logic [CODE_W-1:0] c1);
    @(posedge clk);
    selCode[0] <= c0;
    selCode[1] <= c1;
    repeat (2) @(posedge clk);
    selValid <= 2'b11;
    repeat (3) @(posedge clk);
    selValid <= 2'b00;
    repeat (3) @(posedge clk);
    selCode[0] <= ~c0;
    selCode[1] <= ~c1;
    repeat (4) @(posedge clk);
  endtask : strobe
  task pin_pulse(input logic trig);
    @(posedge clk);
    if (trig)
      trigIn <= 1'b1;
    else
      eventIn <= 1'b1;
    repeat (4) @(posedge clk);
    trigIn <= 1'b0;
    eventIn <= 1'b0;
    repeat (4) @(posedge clk);
  endtask : pin_pulse
  // Segment ends arrive out of step between channels, as two engines would give them.
  always @(posedge clk)
  begin
    pass <= pass + 3'h1;
    segDone[0] <= chOut[0].genRun && pass == 3'h7;
    segDone[1] <= chOut[1].genRun && pass == 3'h3;
  end
endmodule : control_source_model

//--- verif/run_arming_segment_select_test.sv
// Self-checking bench for the run controller.
`timescale 1ns/1ps
module run_arming_segment_select_test;
  import run_ctrl_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic awvalid, wvalid, bready, arvalid, rready;
  logic [7:0] awaddr, araddr, c0, c1;
  logic [31:0] wdata, rdata, d, v;
  logic [3:0] wstrb;
  logic [2:0] awprot, arprot;
  logic awready, wready, bvalid, arready, rvalid, eventIn, trigIn;
  logic [1:0] bresp, rresp, resp;
  logic [CODE_W-1:0] selCode [NUM_CH];
  logic [NUM_CH-1:0] selValid, segDone;
  chOut_t chOut [NUM_CH];
  logic [LEVEL_W-1:0] evtThreshold, trigThreshold;
  int err_total = 0, n_tests = 0, seed = 32'h562e, n, i;
  always #25 clk = ~clk;
  run_arming_segment_select i_dut (.clk, .rst, .awvalid, .awready, .awaddr, .awprot,
    .wvalid, .wready, .wdata, .wstrb, .bvalid, .bready, .bresp, .arvalid, .arready, .araddr,
    .arprot, .rvalid, .rready, .rdata, .rresp, .selCode, .selValid, .eventIn, .trigIn,
    .segDone, .chOut, .evtThreshold, .trigThreshold);
  control_source_model i_src (.clk, .chOut, .selCode, .selValid, .eventIn, .trigIn, .segDone);
  task stop_test;
    $display("checks %0d, mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : stop_test
  task hang;
    err_total++;
    stop_test;
  endtask : hang
  task chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      err_total++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask : chk
  task wr(input logic [7:0] a, input logic [31:0] x);
    @(posedge clk);
    awaddr <= a;
    wdata <= x;
    awprot <= 3'($random(seed));
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (n = 0; n < 100; n++)
    begin
      @(posedge clk);
      if (awready)
        awvalid <= 1'b0;
      if (wready)
        wvalid <= 1'b0;
      if (bvalid)
        break;
    end
    if (n == 100) hang;
    resp = bresp;
    bready <= 1'b0;
  endtask : wr
  task rd(input logic [7:0] a, output logic [31:0] x);
    @(posedge clk);
    araddr <= a;
    arprot <= 3'($random(seed));
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (n = 0; n < 100; n++)
    begin
      @(posedge clk);
      if (arready)
        arvalid <= 1'b0;
      if (rvalid)
        break;
    end
    if (n == 100) hang;
    x = rdata;
    resp = rresp;
    rready <= 1'b0;
  endtask : rd
  task state(input logic ch, input logic [3:0] exp);
    repeat (3) @(posedge clk);
    rd(ch ? 8'h2c : 8'h1c, d);
    chk("state", d & 32'hf, {28'h0, exp});
  endtask : state
  function automatic logic [31:0] clamp(input logic [31:0] x);
    if (x == 32'h0)
      return {12'h0, LOOP_MIN};
    return (x > {12'h0, LOOP_MAX}) ? {12'h0, LOOP_MAX} : x;
  endfunction : clamp
  initial
  begin
    awvalid <= 1'b0;
    wvalid <= 1'b0;
    bready <= 1'b0;
    arvalid <= 1'b0;
    rready <= 1'b0;
    awaddr <= 8'h00;
    araddr <= 8'h00;
    wdata <= 32'h0;
    wstrb <= 4'hf;
    awprot <= 3'h0;
    arprot <= 3'h0;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    rd(8'h10, d);
    chk("ctrl reset", d, CH_CTRL_RST);
    rd(COMMAND_ADDR, d);
    chk("command read", d, 32'h0);
    rd(8'h30, d);
    chk("unmapped data", d, 32'h0);
    chk("unmapped read", resp, RESP_SLVERR);
    wr(8'h30, 32'h1);
    chk("unmapped write", resp, RESP_SLVERR);
    state(1'b0, 4'h1);
    for (i = 0; i < 3; i++)
    begin
      wr(GLOBAL_CFG_ADDR, i);
      rd(GLOBAL_CFG_ADDR, d);
      chk("run mode", d, i);
    end
    for (i = 0; i < 4; i++)
    begin
      v = $random(seed);
      wr(LEVEL_ADDR, v);
      @(posedge clk);
      chk("event level", evtThreshold, v[11:0]);
      chk("trigger level", trigThreshold, v[27:16]);
    end
    // A write with no byte lanes must leave the stored levels alone.
    wstrb <= 4'h0;
    wr(LEVEL_ADDR, 32'h0);
    wstrb <= 4'hf;
    rd(LEVEL_ADDR, d);
    chk("masked level", d, v & LEVEL_MASK);
    for (i = 0; i < 8; i++)
    begin
      v = (i < 2) ? 32'h0 : (i < 4) ? 32'hfffff : $random(seed) & 32'hfffff;
      wr(i[0] ? 8'h18 : 8'h14, v);
      rd(i[0] ? 8'h18 : 8'h14, d);
      chk("loop count", d, clamp(v));
    end
    wr(GLOBAL_CFG_ADDR, 32'h100);
    state(1'b0, 4'h4);
    wr(COMMAND_ADDR, 32'h10);
    i_src.pin_pulse(1'b0);
    state(1'b0, 4'h4);
    wr(8'h20, 32'h200);
    wr(COMMAND_ADDR, 32'h2);
    wr(GLOBAL_CFG_ADDR, 32'h300);
    state(1'b1, 4'h2);
    chk("idle shape", chOut[1].idleShape, IDLE_SEQ);
    i_src.pin_pulse(1'b0);
    state(1'b1, 4'h2);
    wr(COMMAND_ADDR, 32'h8);
    state(1'b1, 4'h4);
    i_src.pin_pulse(1'b0);
    i_src.pin_pulse(1'b1);
    state(1'b1, 4'h4);
    wr(COMMAND_ADDR, 32'h20);
    state(1'b1, 4'h2);
    wr(8'h10, 32'h1041);
    wr(8'h20, 32'h1040);
    wr(GLOBAL_CFG_ADDR, 32'h0);
    wr(COMMAND_ADDR, 32'h3);
    wr(GLOBAL_CFG_ADDR, 32'h300);
    fork
      i_src.pin_pulse(1'b0);
      begin
        for (n = 0; n < 30 && !(chOut[0].genRun || chOut[1].genRun); n++)
          @(posedge clk);
        v = {30'h0, chOut[1].genRun, chOut[0].genRun};
      end
    join
    chk("both enabled", v, 32'h3);
    for (i = 0; i < 4; i++)
    begin
      v = $random(seed);
      c0 = v[7:0];
      c1 = v[15:8];
      i_src.strobe(c0, c1);
      chk("code ch0", chOut[0].activeCode, c0);
      chk("code ch1", chOut[1].activeCode, c1);
    end
    // One pass per step, so the jump flag parks the step at the first segment end.
    wr(8'h14, 32'h1);
    wr(8'h10, 32'h41402);
    i_src.strobe(8'h05, 8'h06);
    repeat (30) @(posedge clk);
    chk("step held", chOut[0].stepIdx, 8'h00);
    chk("sequence code", chOut[0].activeCode, 8'h05);
    i_src.pin_pulse(1'b1);
    repeat (10) @(posedge clk);
    chk("trigger no jump", chOut[0].stepIdx, 8'h00);
    i_src.pin_pulse(1'b0);
    repeat (10) @(posedge clk);
    chk("event jump", chOut[0].stepIdx, 8'h01);
    stop_test;
  end
endmodule : run_arming_segment_select_test
